// *** sirr_pkg.sv ***
// package for the stage input routing register bank
// assumes a single 20 MHz clock domain and a plain register port
package sirr_pkg;
   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int NUM_STAGES      = 12;     // conversion stages
   localparam int NUM_INPUTS      = 13;     // sensor inputs
   localparam int LOW_INPUTS      = 7;      // inputs 0..6 in low register
   localparam int HIGH_INPUTS     = 6;      // inputs 7..12 in high register
   localparam int REG_W           = 16;     // register data width
   localparam int ADDR_W          = 8;      // register address width
   localparam int STAGE_W         = 4;      // stage index width
   localparam int FIELD_W         = 2;      // routing field width

   // ----------------------------------------------------------------
   // register map: two words per stage, stride of eight words
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] STAGE_BASE   = 8'h80;  // stage 0 low
   localparam int                STAGE_STRIDE = 8;      // address words from one stage to the next
   localparam logic [2:0]        LOW_SLOT     = 3'h0;   // low register
   localparam logic [2:0]        HIGH_SLOT    = 3'h1;   // high register

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int MEAS_TYPE_LSB   = 12;     // high reg measurement type
   localparam int NEG_GATE_BIT    = 14;     // high reg negative offset gate
   localparam int POS_GATE_BIT    = 15;     // high reg positive offset gate
   localparam int LOW_USED_W      = 14;     // low reg bits 13:0 in use

   // ----------------------------------------------------------------
   // values after reset (documented as undefined; zero chosen)
   // ----------------------------------------------------------------
   localparam logic [REG_W-1:0]  ROUTE_RESET  = 16'h0000;
   localparam logic [REG_W-1:0]  READ_UNMAPPED = 16'h0000;

   // ----------------------------------------------------------------
   // encodings
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ROUTE_OPEN = 2'b00,   // not connected
      ROUTE_NEG  = 2'b01,   // converter negative input
      ROUTE_POS  = 2'b10,   // converter positive input
      ROUTE_BIAS = 2'b11    // tied to bias
   } sirr_route_type;

   typedef enum logic [1:0] {
      MEAS_RSVD  = 2'b00,   // not to be used
      MEAS_SE_P  = 2'b01,   // single-ended, one input on positive
      MEAS_SE_N  = 2'b10,   // single-ended, one input on negative
      MEAS_DIFF  = 2'b11    // differential
   } sirr_meas_type;
endpackage

// *** sirr_stage_if.sv ***
// interface carrying one stage's settings from the bank to the switch
// assumes both ends sit on the same clock
`timescale 1ns/1ps
`default_nettype none
interface sirr_stage_if;
   import sirr_pkg::*;
   logic                 active;     // sequencer converting a stage
   logic [REG_W-1:0]     low_word;   // selected stage low register
   logic [REG_W-1:0]     high_word;  // selected stage high register
   modport bank   (output active, output low_word, output high_word);
   modport matrix (input  active, input  low_word, input  high_word);
endinterface
`default_nettype wire

// *** sirr_switch_decode.sv ***
// decoder that turns a stage's settings into switch matrix controls
// assumes settings arrive registered from the bank on the same clock
`timescale 1ns/1ps
`default_nettype none
module sirr_switch_decode (
   input  wire logic                          ref_clk_i,
   input  wire logic                          reset_i,
   sirr_stage_if.matrix                       stg,
   output logic [sirr_pkg::NUM_INPUTS-1:0]    neg_sw_o,
   output logic [sirr_pkg::NUM_INPUTS-1:0]    pos_sw_o,
   output logic [sirr_pkg::NUM_INPUTS-1:0]    bias_sw_o,
   output logic [1:0]                         meas_type_o,
   output logic                               neg_offset_en_o,
   output logic                               pos_offset_en_o
);
   import sirr_pkg::*;

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   logic [NUM_INPUTS*FIELD_W-1:0] fields;      // all 13 fields packed
   logic [NUM_INPUTS-1:0]         nxt_neg;     // next negative switches
   logic [NUM_INPUTS-1:0]         nxt_pos;     // next positive switches
   logic [NUM_INPUTS-1:0]         nxt_bias;    // next bias switches
   logic [1:0]                    nxt_meas;    // next measurement type
   logic                          nxt_neg_en;  // next negative offset on
   logic                          nxt_pos_en;  // next positive offset on
   logic [NUM_INPUTS-1:0]         neg_ff;
   logic [NUM_INPUTS-1:0]         pos_ff;
   logic [NUM_INPUTS-1:0]         bias_ff;
   logic [1:0]                    meas_ff;
   logic                          neg_en_ff;
   logic                          pos_en_ff;

   // inputs 0..6 from low word, 7..12 from high word
   assign fields = {stg.high_word[HIGH_INPUTS*FIELD_W-1:0],
                    stg.low_word[LOW_INPUTS*FIELD_W-1:0]};

   // all switches open while no stage is being converted
   always_comb begin
      nxt_neg    = '0;
      nxt_pos    = '0;
      nxt_bias   = '0;
      nxt_meas   = MEAS_RSVD;
      nxt_neg_en = 1'b0;
      nxt_pos_en = 1'b0;
      if (stg.active) begin                              // see RULE_15
         for (int i = 0; i < NUM_INPUTS; i++) begin
            case (sirr_route_type'(fields[i*FIELD_W +: FIELD_W]))
               ROUTE_OPEN: ;                             // see RULE_02
               ROUTE_NEG:  nxt_neg[i]  = 1'b1;           // see RULE_03
               ROUTE_POS:  nxt_pos[i]  = 1'b1;           // see RULE_04
               ROUTE_BIAS: nxt_bias[i] = 1'b1;           // see RULE_05
               default:    ;
            endcase
         end
         // measurement type passes to the converter as coded
         nxt_meas   = stg.high_word[MEAS_TYPE_LSB +: 2]; // see RULE_10
         // a set gate bit disables the offset
         nxt_neg_en = ~stg.high_word[NEG_GATE_BIT];      // see RULE_11
         nxt_pos_en = ~stg.high_word[POS_GATE_BIT];      // see RULE_12
      end
   end

   // register the controls so outputs come from flip-flops
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         neg_ff    <= '0;
         pos_ff    <= '0;
         bias_ff   <= '0;
         meas_ff   <= MEAS_RSVD;
         neg_en_ff <= 1'b0;
         pos_en_ff <= 1'b0;
      end else begin
         neg_ff    <= nxt_neg;
         pos_ff    <= nxt_pos;
         bias_ff   <= nxt_bias;
         meas_ff   <= nxt_meas;
         neg_en_ff <= nxt_neg_en;
         pos_en_ff <= nxt_pos_en;
      end
   end

   assign neg_sw_o        = neg_ff;
   assign pos_sw_o        = pos_ff;
   assign bias_sw_o       = bias_ff;
   assign meas_type_o     = meas_ff;
   assign neg_offset_en_o = neg_en_ff;
   assign pos_offset_en_o = pos_en_ff;
endmodule
`default_nettype wire

// *** sirr_stage_select.sv ***
// selector that latches the stage under conversion from the sequencer
// assumes the sequencer sits on the same clock as the bank
`timescale 1ns/1ps
`default_nettype none
module sirr_stage_select (
   input  wire logic                          ref_clk_i,
   input  wire logic                          reset_i,
   input  wire logic                          conv_active_i,
   input  wire logic [sirr_pkg::STAGE_W-1:0]  conv_stage_i,
   output logic                               active_o,
   output logic [sirr_pkg::STAGE_W-1:0]       stage_o
);
   import sirr_pkg::*;

   // ----------------------------------------------------------------
   // stage latch
   // ----------------------------------------------------------------
   logic                active_ff;   // a valid stage is being converted
   logic [STAGE_W-1:0]  stage_ff;    // stage index under conversion
   logic                nxt_active;
   logic [STAGE_W-1:0]  nxt_stage;

   // out-of-range stage numbers count as idle
   always_comb begin
      nxt_active = conv_active_i &&
                   (conv_stage_i < STAGE_W'(NUM_STAGES));
      nxt_stage  = nxt_active ? conv_stage_i : stage_ff;
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         active_ff <= 1'b0;
         stage_ff  <= '0;
      end else begin
         active_ff <= nxt_active;
         stage_ff  <= nxt_stage;
      end
   end

   assign active_o = active_ff;
   assign stage_o  = stage_ff;
endmodule
`default_nettype wire

// *** sirr_top.sv ***
// top of the stage input routing register bank with switch decode
// assumes one 20 MHz clock, synchronous reset, same-clock sequencer
//
// Summary of operation
// RULE_01 - low register: fields for inputs 0..6
// RULE_02 - code 00 leaves the input open
// RULE_03 - code 01 routes input to negative
// RULE_04 - code 10 routes input to positive
// RULE_05 - code 11 ties input to bias
// RULE_06 - high register: fields for inputs 7..12
// RULE_07 - software never writes measurement type 00
// RULE_08 - type 01: one input on positive
// RULE_09 - type 10: one input on negative
// RULE_10 - type 11 selects differential connection
// RULE_11 - bit 14 set disables negative offset
// RULE_12 - bit 15 set disables positive offset
// RULE_13 - twelve stages, each with its pair
// RULE_14 - software writes zero to low bits 15:14
// RULE_15 - settings reach switches only while converting
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module sirr_top (
   input  wire logic                          ref_clk_i,
   input  wire logic                          reset_i,
   input  wire logic [sirr_pkg::ADDR_W-1:0]   addr_i,
   input  wire logic [sirr_pkg::REG_W-1:0]    wdata_i,
   input  wire logic                          wr_i,
   input  wire logic                          rd_i,
   output logic [sirr_pkg::REG_W-1:0]         rdata_o,
   input  wire logic                          conv_active_i,
   input  wire logic [sirr_pkg::STAGE_W-1:0]  conv_stage_i,
   output logic [sirr_pkg::STAGE_W-1:0]       conv_stage_o,
   output logic [sirr_pkg::NUM_INPUTS-1:0]    neg_sw_o,
   output logic [sirr_pkg::NUM_INPUTS-1:0]    pos_sw_o,
   output logic [sirr_pkg::NUM_INPUTS-1:0]    bias_sw_o,
   output logic [1:0]                         meas_type_o,
   output logic                               neg_offset_en_o,
   output logic                               pos_offset_en_o
);
   import sirr_pkg::*;

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   // decoded hit: stage index, low or high slot
   typedef struct packed {
      logic               hit;
      logic               high;
      logic [STAGE_W-1:0] stage;
   } sirr_hit_type;

   // map an address onto a stage register, or report a miss
   function automatic sirr_hit_type decode(input logic [ADDR_W-1:0] a);
      sirr_hit_type      d;
      logic [ADDR_W-1:0] off;
      d     = '0;
      off   = a - STAGE_BASE;
      if (a >= STAGE_BASE &&
          off < ADDR_W'(NUM_STAGES * STAGE_STRIDE) &&
          (off[2:0] == LOW_SLOT || off[2:0] == HIGH_SLOT)) begin
         d.hit   = 1'b1;
         d.high  = (off[2:0] == HIGH_SLOT);
         d.stage = off[STAGE_W+2:3];
      end
      return d;
   endfunction

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   logic [REG_W-1:0] low_ff  [NUM_STAGES];  // low routing per stage
   logic [REG_W-1:0] high_ff [NUM_STAGES];  // high routing per stage
   logic [REG_W-1:0] nxt_low  [NUM_STAGES];
   logic [REG_W-1:0] nxt_high [NUM_STAGES];
   logic [REG_W-1:0] rdata_ff;              // read data, one cycle on
   logic [REG_W-1:0] nxt_rdata;
   sirr_hit_type     wr_hit;                // write decode
   sirr_hit_type     rd_hit;                // read decode

   assign wr_hit = decode(addr_i);
   assign rd_hit = decode(addr_i);

   // write path: each stage has its own independent pair
   always_comb begin
      for (int s = 0; s < NUM_STAGES; s++) begin       // see RULE_13
         nxt_low[s]  = low_ff[s];
         nxt_high[s] = high_ff[s];
      end
      if (wr_i && wr_hit.hit) begin
         if (wr_hit.high) begin
            // all 16 bits stored: fields, type, gates
            nxt_high[wr_hit.stage] = wdata_i;          // see RULE_06
         end else begin
            // bits 15:14 unused and kept at zero
            nxt_low[wr_hit.stage] =
               {2'b00, wdata_i[LOW_USED_W-1:0]};       // see RULE_01
         end
      end
   end

   // read path: data valid in the cycle after the strobe only
   always_comb begin
      nxt_rdata = READ_UNMAPPED;
      if (rd_i && rd_hit.hit) begin
         if (rd_hit.high) begin
            nxt_rdata = high_ff[rd_hit.stage];
         end else begin
            nxt_rdata = low_ff[rd_hit.stage];
         end
      end
   end

   // registers
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         for (int s = 0; s < NUM_STAGES; s++) begin
            low_ff[s]  <= ROUTE_RESET;
            high_ff[s] <= ROUTE_RESET;
         end
         rdata_ff <= READ_UNMAPPED;
      end else begin
         for (int s = 0; s < NUM_STAGES; s++) begin
            low_ff[s]  <= nxt_low[s];
            high_ff[s] <= nxt_high[s];
         end
         rdata_ff <= nxt_rdata;
      end
   end

   assign rdata_o = rdata_ff;

   // ----------------------------------------------------------------
   // stage under conversion
   // ----------------------------------------------------------------
   logic               sel_active;   // valid stage latched
   logic [STAGE_W-1:0] sel_stage;    // latched stage index

   sirr_stage_select u_sel (
      .ref_clk_i     (ref_clk_i),
      .reset_i       (reset_i),
      .conv_active_i (conv_active_i),
      .conv_stage_i  (conv_stage_i),
      .active_o      (sel_active),
      .stage_o       (sel_stage)
   );

   assign conv_stage_o = sel_stage;

   // ----------------------------------------------------------------
   // switch matrix drive
   // ----------------------------------------------------------------
   sirr_stage_if stg ();

   // only the stage being converted feeds the matrix
   assign stg.active    = sel_active;                  // see RULE_15
   assign stg.low_word  = low_ff[sel_stage];
   assign stg.high_word = high_ff[sel_stage];

   sirr_switch_decode u_dec (
      .ref_clk_i       (ref_clk_i),
      .reset_i         (reset_i),
      .stg             (stg),
      .neg_sw_o        (neg_sw_o),
      .pos_sw_o        (pos_sw_o),
      .bias_sw_o       (bias_sw_o),
      .meas_type_o     (meas_type_o),
      .neg_offset_en_o (neg_offset_en_o),
      .pos_offset_en_o (pos_offset_en_o)
   );
endmodule
`default_nettype wire

// *** sirr_top_sva.sv ***
// checker for the stage input routing register bank
// assumes it is bound into sirr_top and sees only that module's ports
`timescale 1ns/1ps
`default_nettype none
module sirr_top_sva
   import sirr_pkg::*;
(
   input wire logic                  ref_clk_i,
   input wire logic                  reset_i,
   input wire logic [ADDR_W-1:0]     addr_i,
   input wire logic [REG_W-1:0]      wdata_i,
   input wire logic                  wr_i,
   input wire logic                  rd_i,
   input wire logic [REG_W-1:0]      rdata_o,
   input wire logic                  conv_active_i,
   input wire logic [STAGE_W-1:0]    conv_stage_i,
   input wire logic [STAGE_W-1:0]    conv_stage_o,
   input wire logic [NUM_INPUTS-1:0] neg_sw_o,
   input wire logic [NUM_INPUTS-1:0] pos_sw_o,
   input wire logic [NUM_INPUTS-1:0] bias_sw_o,
   input wire logic [1:0]            meas_type_o,
   input wire logic                  neg_offset_en_o,
   input wire logic                  pos_offset_en_o
);
   // ----------------------------------------------------------------
   // shadow of the bank, built from the writes seen at the port
   // ----------------------------------------------------------------
   logic [REG_W-1:0]      low_ff  [NUM_STAGES]; // shadow low words
   logic [REG_W-1:0]      high_ff [NUM_STAGES]; // shadow high words
   logic [ADDR_W-1:0]     off;                  // offset into the map
   logic                  mapped;               // address hits a word
   logic                  act1_ff, act2_ff;     // valid stage pipeline
   logic [STAGE_W-1:0]    st1_ff, st2_ff;       // stage pipeline
   logic [REG_W-1:0]      rd_exp_ff, rd_look;   // expected read data
   logic [25:0]           fields;               // all thirteen fields
   logic [NUM_INPUTS-1:0] e_neg, e_pos, e_bias; // expected switches
   logic [REG_W-1:0]      wh;                   // high word in use
   assign off     = addr_i - STAGE_BASE;
   assign mapped  = addr_i >= STAGE_BASE && off[6:3] < 4'd12
                    && off[2:1] == 2'b00;
   assign rd_look = !mapped ? 16'h0000 : off[0] ? high_ff[off[6:3]]
                    : low_ff[off[6:3]] & 16'h3FFF;
   assign wh      = high_ff[st2_ff];
   assign fields  = {wh[11:0], low_ff[st2_ff][13:0]};
   // decode every field of the stage two cycles back
   always_comb begin
      for (int i = 0; i < NUM_INPUTS; i++) begin
         e_neg[i]  = fields[2*i +: 2] == 2'b01;
         e_pos[i]  = fields[2*i +: 2] == 2'b10;
         e_bias[i] = fields[2*i +: 2] == 2'b11;
      end
   end
   // shadow words and sample pipeline, cleared like the design
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         for (int k = 0; k < NUM_STAGES; k++) begin
            low_ff[k]  <= '0;
            high_ff[k] <= '0;
         end
         act1_ff   <= 1'b0;
         act2_ff   <= 1'b0;
         st1_ff    <= '0;
         st2_ff    <= '0;
         rd_exp_ff <= '0;
      end else begin
         if (wr_i && mapped && !off[0]) low_ff[off[6:3]] <= wdata_i;
         if (wr_i && mapped && off[0]) high_ff[off[6:3]] <= wdata_i;
         act1_ff   <= conv_active_i && conv_stage_i < 4'd12;
         act2_ff   <= act1_ff;
         st1_ff    <= conv_stage_i;
         st2_ff    <= st1_ff;
         rd_exp_ff <= rd_i ? rd_look : 16'h0000;
      end
   end
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);
   a_read_word: assert property (
      $past(rd_i) |-> rdata_o == rd_exp_ff) else $error("read word wrong");
   a_read_idle: assert property (
      !$past(rd_i) |-> rdata_o == 16'h0000) else $error("read data lingers");
   a_route_neg: assert property (
      act2_ff && !$past(wr_i) |-> neg_sw_o == e_neg) else $error("neg route");
   a_route_pos: assert property (
      act2_ff && !$past(wr_i) |-> pos_sw_o == e_pos) else $error("pos route");
   a_route_bias: assert property (
      act2_ff && !$past(wr_i) |-> bias_sw_o == e_bias) else $error("bias");
   a_meas_type: assert property (
      act2_ff && !$past(wr_i) |-> meas_type_o == wh[13:12])
      else $error("measurement type wrong");
   a_neg_gate: assert property (
      act2_ff && !$past(wr_i) |-> neg_offset_en_o == !wh[14])
      else $error("negative offset gate wrong");
   a_pos_gate: assert property (
      act2_ff && !$past(wr_i) |-> pos_offset_en_o == !wh[15])
      else $error("positive offset gate wrong");
   a_idle_quiet: assert property (
      !act2_ff |-> (neg_sw_o | pos_sw_o | bias_sw_o) == '0
      && meas_type_o == 2'b00 && !neg_offset_en_o && !pos_offset_en_o)
      else $error("switches driven while idle");
   a_stage_latch: assert property (
      act1_ff |-> conv_stage_o == st1_ff) else $error("stage latch wrong");
   c_read: cover property (rd_i && mapped);
   c_last_stage: cover property (act2_ff && st2_ff == 4'd11);
   c_high_write: cover property (wr_i && mapped && off[0]);
endmodule
bind sirr_top sirr_top_sva i_sirr_top_sva (.ref_clk_i(ref_clk_i),
   .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
   .rd_i(rd_i), .rdata_o(rdata_o), .conv_active_i(conv_active_i),
   .conv_stage_i(conv_stage_i), .conv_stage_o(conv_stage_o),
   .neg_sw_o(neg_sw_o), .pos_sw_o(pos_sw_o), .bias_sw_o(bias_sw_o),
   .meas_type_o(meas_type_o), .neg_offset_en_o(neg_offset_en_o),
   .pos_offset_en_o(pos_offset_en_o));
`default_nettype wire

// *** test_sirr_top.sv ***
// testbench for the stage input routing register bank
// assumes sirr_top with its checker bound in, one 20 MHz clock
`timescale 1ns/1ps
`default_nettype none
module test_sirr_top;
   import sirr_pkg::*;
   logic                  ref_clk_i, reset_i, wr_i, rd_i, conv_active_i;
   logic [ADDR_W-1:0]     addr_i;
   logic [REG_W-1:0]      wdata_i, rdata_o;
   logic [STAGE_W-1:0]    conv_stage_i, conv_stage_o;
   logic [NUM_INPUTS-1:0] neg_sw_o, pos_sw_o, bias_sw_o;
   logic [1:0]            meas_type_o;
   logic                  neg_offset_en_o, pos_offset_en_o;
   int                    mismatches, total_checks, cycles;
   logic [STAGE_W-1:0]    exp_stage;   // stage the latch should hold
   sirr_top i_sirr_top (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .conv_active_i(conv_active_i),
      .conv_stage_i(conv_stage_i), .conv_stage_o(conv_stage_o),
      .neg_sw_o(neg_sw_o), .pos_sw_o(pos_sw_o), .bias_sw_o(bias_sw_o),
      .meas_type_o(meas_type_o), .neg_offset_en_o(neg_offset_en_o),
      .pos_offset_en_o(pos_offset_en_o));
   // 50 ns clock
   initial begin
      ref_clk_i = 1'b0;
      forever #25 ref_clk_i = ~ref_clk_i;
   end
   // closing report
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   function automatic logic [ADDR_W-1:0] ad(int s, int h);
      return ADDR_W'(int'(STAGE_BASE) + STAGE_STRIDE * s + h);
   endfunction
   // one-cycle write strobe
   task automatic wr(logic [ADDR_W-1:0] a, logic [REG_W-1:0] d);
      @(posedge ref_clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
   endtask
   // one-cycle read strobe, data looked at in the following cycle
   task automatic rd(logic [ADDR_W-1:0] a, logic [REG_W-1:0] exp);
      @(posedge ref_clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      @(negedge ref_clk_i);
      chk("rdata", rdata_o, exp);
   endtask
   // convert one stage and compare the switch outputs with the words
   task automatic sw(logic act, logic [3:0] s, logic [15:0] lo, hi);
      logic [25:0] f;
      logic [15:0] n, p, b;
      logic        on;
      on = act && s < 4'd12;
      if (on) exp_stage = s;
      f = {hi[11:0], lo[13:0]};
      n = '0;
      p = '0;
      b = '0;
      for (int i = 0; i < NUM_INPUTS; i++) begin
         n[i] = on && f[2*i +: 2] == 2'b01;
         p[i] = on && f[2*i +: 2] == 2'b10;
         b[i] = on && f[2*i +: 2] == 2'b11;
      end
      @(posedge ref_clk_i);
      conv_active_i <= act;
      conv_stage_i <= s;
      repeat (3) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      chk("conv_stage", 16'(conv_stage_o), 16'(exp_stage));
      chk("neg_sw", 16'(neg_sw_o), n);
      chk("pos_sw", 16'(pos_sw_o), p);
      chk("bias_sw", 16'(bias_sw_o), b);
      chk("meas_type", 16'(meas_type_o), on ? 16'(hi[13:12]) : '0);
      chk("neg_offset", 16'(neg_offset_en_o), 16'(on & !hi[14]));
      chk("pos_offset", 16'(pos_offset_en_o), 16'(on & !hi[15]));
   endtask
   // hang guard
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         end_sim();
      end
   end
   initial begin
      {reset_i, wr_i, rd_i, conv_active_i} = 4'b1000;
      addr_i = '0;
      wdata_i = '0;
      conv_stage_i = '0;
      exp_stage = '0;
      repeat (10) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      rd(ad(0, 0), 16'h0000);
      rd(ad(11, 1), 16'h0000);
      for (int s = 0; s < NUM_STAGES; s++) begin
         wr(ad(s, 0), 16'h2A5A ^ 16'(s));
         wr(ad(s, 1), 16'hD3C0 ^ 16'(s));
      end
      for (int s = 0; s < NUM_STAGES; s++) begin
         rd(ad(s, 0), 16'h2A5A ^ 16'(s));
         rd(ad(s, 1), 16'hD3C0 ^ 16'(s));
      end
      // unmapped places read zero and keep nothing
      wr(8'h82, 16'hFFFF);
      rd(8'h82, 16'h0000);
      rd(8'h7F, 16'h0000);
      rd(8'hE0, 16'h0000);
      rd(ad(0, 1), 16'hD3C0);
      // every code and gate setting, host typing kept consistent
      wr(ad(5, 0), 16'h24E4);
      wr(ad(5, 1), 16'h7E43);
      wr(ad(11, 0), 16'h3FF2);
      wr(ad(11, 1), 16'h9FFF);
      wr(ad(0, 0), 16'h3FF1);
      wr(ad(0, 1), 16'h6FFF);
      wr(ad(7, 0), 16'h3FE6);
      wr(ad(7, 1), 16'h3FFF);
      sw(1'b1, 4'd5, 16'h24E4, 16'h7E43);
      sw(1'b1, 4'd11, 16'h3FF2, 16'h9FFF);
      sw(1'b1, 4'd0, 16'h3FF1, 16'h6FFF);
      sw(1'b1, 4'd7, 16'h3FE6, 16'h3FFF);
      wr(ad(7, 1), 16'hFFFF); // write to the stage under conversion
      sw(1'b1, 4'd7, 16'h3FE6, 16'hFFFF);
      sw(1'b1, 4'd12, 16'h0000, 16'h0000);
      sw(1'b0, 4'd5, 16'h0000, 16'h0000);
      // second reset in mid-run clears the bank
      @(posedge ref_clk_i);
      reset_i <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      rd(ad(5, 0), 16'h0000);
      end_sim();
   end
endmodule
`default_nettype wire
